/* File: hdl/uart_char_tx.sv */
// one twelve-bit uart character shifter with its own baud divider
`timescale 1ns/1ps
`default_nettype none

module uart_char_tx #(
    parameter int BAUD_DIV = uart_txq_pkg::BAUD_DIV_DEF
) (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_clr,
    // character request
    input  wire logic       i_start,
    input  wire logic [7:0] i_char,
    input  wire logic       i_odd,
    // line and status
    output logic            o_txd,
    output logic            o_busy,
    output logic            o_done
);
    import uart_txq_pkg::*;

    localparam logic [15:0] DIV_LAST = 16'(BAUD_DIV - 1);

    logic [15:0] div_cnt;
    logic        baud_en;
    logic [11:0] shift_reg;
    logic [3:0]  bits_left;
    logic        par_bit;

    // parity even by default, odd when i_odd is set
    assign par_bit = i_odd ? ~(^i_char) : (^i_char);
    assign baud_en = o_busy && (div_cnt == DIV_LAST);

    // bit-time divider, runs only while a character is out
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            div_cnt <= 16'h0000;
        end else if (i_clr || !o_busy || baud_en) begin
            div_cnt <= 16'h0000;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
        end
    end

    // start, data lsb first, parity, two stops
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            shift_reg <= 12'hfff;
            bits_left <= 4'h0;
            o_txd     <= 1'b1;
            o_busy    <= 1'b0;
            o_done    <= 1'b0;
        end else if (i_clr) begin
            shift_reg <= 12'hfff;
            bits_left <= 4'h0;
            o_txd     <= 1'b1;
            o_busy    <= 1'b0;
            o_done    <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start && !o_busy) begin
                shift_reg <= {2'b11, par_bit, i_char, 1'b0};
                bits_left <= 4'(CHAR_BITS);
                o_txd     <= 1'b0;
                o_busy    <= 1'b1;
            end else if (baud_en) begin
                shift_reg <= {1'b1, shift_reg[11:1]};
                bits_left <= bits_left - 4'h1;
                o_txd     <= shift_reg[1];
                if (bits_left == 4'h1) begin
                    o_txd  <= 1'b1;
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                end
            end
        end
    end

endmodule

`default_nettype wire

/* File: hdl/uart_tx_queue.sv */
// transmit queue, mode arbitration and framing for the uart bridge
`timescale 1ns/1ps
`default_nettype none

module uart_tx_queue #(
    parameter int BAUD_DIV      = uart_txq_pkg::BAUD_DIV_DEF,
    parameter int KA_MAX_CYCLES = uart_txq_pkg::KA_MAX_CYCLES
) (
    // clock and reset
    input  wire logic       I_CLK,
    input  wire logic       I_RESET_N,
    input  wire logic       I_SHUTDOWN,
    // host buffer access
    input  wire logic       I_BUF_WR,
    input  wire logic [2:0] I_BUF_LOC,
    input  wire logic [7:0] I_BUF_WDATA,
    input  wire logic [2:0] I_BUF_RD_LOC,
    input  wire logic       I_CLEAR_CMD,
    input  wire logic       I_ADVANCE_CMD,
    input  wire logic       I_OVF_CLR,
    output logic      [7:0] O_BUF_RDATA,
    // transmit and receive modes
    input  wire logic       I_TX_QUEUE,
    input  wire logic       I_TX_PREAMBLES,
    input  wire logic [3:0] I_KEEP_ALIVE,
    input  wire logic       I_TX_UNLIMITED,
    input  wire logic       I_TX_PAUSE,
    input  wire logic       I_TX_ODD_PARITY,
    input  wire logic       I_TX_NO_STOP,
    input  wire logic       I_TX_NO_PREAMBLE,
    input  wire logic       I_TX_RAW,
    input  wire logic       I_RX_RAW,
    // receive buffer state
    input  wire logic       I_RX_FULL,
    input  wire logic [7:0] I_RX_SPACE,
    // line and status
    output logic            O_TXD,
    output logic            O_TX_BUSY,
    output logic            O_TX_IDLE,
    output logic            O_TX_EMPTY,
    output logic            O_TX_FULL,
    output logic            O_TX_OVERFLOW,
    output logic      [1:0] O_LOAD_SLOT,
    output logic      [1:0] O_TX_SLOT,
    output logic            O_RX_RAW
);
    import uart_txq_pkg::*;

    logic [7:0]  buf_mem [NUM_SLOTS][SLOT_BYTES];
    logic        sd_meta;
    logic        sd_sync;
    logic        buf_clr;
    logic [1:0]  load_slot_pointer;
    logic [1:0]  transmit_slot_pointer;
    logic        ptr_equal;
    logic        ptr_full;
    tx_state_t   st_reg;
    logic        wait_reg;
    logic        nib_reg;
    logic [7:0]  idx_reg;
    logic [7:0]  len_reg;
    logic [7:0]  single_reg;
    logic [31:0] ka_cnt;
    logic [31:0] ka_limit;
    logic        ka_fire;
    logic        can_start;
    logic [7:0]  cur_byte;
    logic [7:0]  char_data;
    logic        issuing;
    logic        char_start;
    logic        char_busy;
    logic        char_done;
    logic [7:0]  len_cap;

    // default contents of one slot location
    function automatic logic [7:0] def_byte(input int loc);
        def_byte = (loc == 0) ? LEN_DEFAULT :
                   (loc % 2 == 1) ? FILL_ODD : FILL_EVEN;
    endfunction

    // nibble to manchester character, info bit first
    function automatic logic [7:0] manch(input logic [3:0] n);
        manch = {~n[3], n[3], ~n[2], n[2], ~n[1], n[1], ~n[0], n[0]};
    endfunction

    // shutdown pin synchroniser
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            sd_meta <= 1'b0;
            sd_sync <= 1'b0;
        end else begin
            sd_meta <= I_SHUTDOWN;
            sd_sync <= sd_meta;
        end
    end

    assign buf_clr   = sd_sync || I_CLEAR_CMD;
    assign ptr_equal = (load_slot_pointer == transmit_slot_pointer);
    assign ptr_full  = (load_slot_pointer == transmit_slot_pointer - 2'h1);
    assign len_cap   = I_TX_UNLIMITED ? LEN_LIMIT_UNL : LEN_LIMIT;

    // slot pointers and overflow flag
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            load_slot_pointer     <= SLOT_FIRST;
            transmit_slot_pointer <= SLOT_FIRST;
            O_TX_OVERFLOW         <= 1'b0;
        end else if (buf_clr) begin
            load_slot_pointer     <= SLOT_FIRST;
            transmit_slot_pointer <= SLOT_FIRST;
            O_TX_OVERFLOW         <= 1'b0;
        end else begin
            if (I_ADVANCE_CMD && ptr_full) begin
                O_TX_OVERFLOW <= 1'b1;
            end else if (I_OVF_CLR) begin
                O_TX_OVERFLOW <= 1'b0;
            end
            if (I_ADVANCE_CMD && !ptr_full) begin
                load_slot_pointer <= load_slot_pointer + 2'h1;
            end
            if (st_reg == ST_DONE) begin
                transmit_slot_pointer <= transmit_slot_pointer + 2'h1;
            end
        end
    end

    // buffer storage: clear, restore after send, host writes
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            for (int s = 0; s < NUM_SLOTS; s++) begin
                for (int b = 0; b < SLOT_BYTES; b++) begin
                    buf_mem[s][b] <= def_byte(b);
                end
            end
        end else if (buf_clr) begin
            for (int s = 0; s < NUM_SLOTS; s++) begin
                for (int b = 0; b < SLOT_BYTES; b++) begin
                    buf_mem[s][b] <= def_byte(b);
                end
            end
        end else begin
            if (st_reg == ST_DONE) begin
                for (int b = 0; b < SLOT_BYTES; b++) begin
                    buf_mem[transmit_slot_pointer][b] <= def_byte(b);
                end
            end
            if (I_BUF_WR && I_BUF_LOC <= LOC_LAST) begin
                if (I_BUF_LOC == LOC_LEN && I_BUF_WDATA > len_cap) begin
                    buf_mem[load_slot_pointer][LOC_LEN] <= len_cap;
                end else begin
                    buf_mem[load_slot_pointer][I_BUF_LOC] <= I_BUF_WDATA;
                end
            end
        end
    end

    // read-back of the load slot, zero past the last location
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_BUF_RDATA <= 8'h00;
        end else if (I_BUF_RD_LOC <= LOC_LAST) begin
            O_BUF_RDATA <= buf_mem[load_slot_pointer][I_BUF_RD_LOC];
        end else begin
            O_BUF_RDATA <= 8'h00;
        end
    end

    // start conditions and keep-alive timing
    assign can_start = I_TX_QUEUE && !ptr_equal
                       && (I_TX_UNLIMITED || (!I_RX_FULL
                       && I_RX_SPACE >= buf_mem[transmit_slot_pointer][LOC_LEN]));
    assign ka_limit  = KA_MAX_CYCLES >> (KA_TOP - I_KEEP_ALIVE);
    assign ka_fire   = (I_KEEP_ALIVE == KA_ZERO)
                       || (I_KEEP_ALIVE != KA_OFF && ka_cnt + 32'h1 >= ka_limit);

    // idle interval counter, restarts on any line activity
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ka_cnt <= 32'h0;
        end else if (sd_sync || st_reg != ST_IDLE || char_busy
                     || I_KEEP_ALIVE == KA_OFF) begin
            ka_cnt <= 32'h0;
        end else if (!ka_fire) begin
            ka_cnt <= ka_cnt + 32'h1;
        end
    end

    // current message byte: stored data or generated fill
    assign cur_byte = (idx_reg > LAST_STORED)
                      ? (idx_reg[0] ? FILL_ODD : FILL_EVEN)
                      : buf_mem[transmit_slot_pointer][idx_reg[2:0]];

    // character chosen by the sequencer
    always_comb begin
        case (st_reg)
            ST_SINGLE: char_data = single_reg;
            ST_PRE:    char_data = PREAMBLE_CHAR;
            ST_STOP:   char_data = STOP_CHAR;
            ST_DATA: begin
                if (I_TX_RAW) begin
                    char_data = cur_byte;
                end else begin
                    char_data = manch(nib_reg ? cur_byte[7:4] : cur_byte[3:0]);
                end
            end
            default:   char_data = 8'h00;
        endcase
    end

    assign issuing    = (st_reg == ST_SINGLE) || (st_reg == ST_PRE)
                        || (st_reg == ST_DATA) || (st_reg == ST_STOP);
    assign char_start = issuing && !wait_reg && !char_busy
                        && !I_TX_PAUSE && !sd_sync;

    // transmit sequencer
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            st_reg     <= ST_IDLE;
            wait_reg   <= 1'b0;
            nib_reg    <= 1'b0;
            idx_reg    <= 8'h00;
            len_reg    <= 8'h00;
            single_reg <= STOP_CHAR;
        end else if (buf_clr) begin
            st_reg   <= ST_IDLE;
            wait_reg <= 1'b0;
            nib_reg  <= 1'b0;
            idx_reg  <= 8'h00;
        end else begin
            if (char_start) begin
                wait_reg <= 1'b1;
            end
            case (st_reg)
                ST_IDLE: begin
                    if (I_TX_PAUSE || char_busy) begin
                        st_reg <= ST_IDLE;
                    end else if (I_TX_PREAMBLES) begin
                        single_reg <= PREAMBLE_CHAR;
                        st_reg     <= ST_SINGLE;
                    end else if (can_start) begin
                        len_reg <= buf_mem[transmit_slot_pointer][LOC_LEN];
                        idx_reg <= 8'h01;
                        nib_reg <= 1'b0;
                        if (!I_TX_NO_PREAMBLE) begin
                            st_reg <= ST_PRE;
                        end else if (buf_mem[transmit_slot_pointer][LOC_LEN]
                                     != LEN_DEFAULT) begin
                            st_reg <= ST_DATA;
                        end else begin
                            st_reg <= I_TX_NO_STOP ? ST_DONE : ST_STOP;
                        end
                    end else if (ka_fire) begin
                        single_reg <= STOP_CHAR;
                        st_reg     <= ST_SINGLE;
                    end
                end
                ST_SINGLE: begin
                    if (wait_reg && char_done) begin
                        wait_reg <= 1'b0;
                        st_reg   <= ST_IDLE;
                    end
                end
                ST_PRE: begin
                    if (wait_reg && char_done) begin
                        wait_reg <= 1'b0;
                        if (len_reg != LEN_DEFAULT) begin
                            st_reg <= ST_DATA;
                        end else begin
                            st_reg <= I_TX_NO_STOP ? ST_DONE : ST_STOP;
                        end
                    end
                end
                ST_DATA: begin
                    if (wait_reg && char_done) begin
                        wait_reg <= 1'b0;
                        if (!I_TX_RAW && !nib_reg) begin
                            nib_reg <= 1'b1;
                        end else if (idx_reg == len_reg) begin
                            nib_reg <= 1'b0;
                            st_reg  <= I_TX_NO_STOP ? ST_DONE : ST_STOP;
                        end else begin
                            nib_reg <= 1'b0;
                            idx_reg <= idx_reg + 8'h01;
                        end
                    end
                end
                ST_STOP: begin
                    if (wait_reg && char_done) begin
                        wait_reg <= 1'b0;
                        st_reg   <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    st_reg <= ST_IDLE;
                end
                default: begin
                    st_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // status outputs; busy and idle frozen while paused unless shut down
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_TX_BUSY   <= 1'b0;
            O_TX_IDLE   <= 1'b1;
            O_TX_EMPTY  <= 1'b1;
            O_TX_FULL   <= 1'b0;
            O_LOAD_SLOT <= SLOT_FIRST;
            O_TX_SLOT   <= SLOT_FIRST;
            O_RX_RAW    <= 1'b0;
        end else begin
            if (!I_TX_PAUSE || sd_sync) begin
                O_TX_BUSY <= (st_reg != ST_IDLE) || char_busy;
                O_TX_IDLE <= (st_reg == ST_IDLE) && !char_busy;
            end
            O_TX_EMPTY  <= ptr_equal;
            O_TX_FULL   <= ptr_full;
            O_LOAD_SLOT <= load_slot_pointer;
            O_TX_SLOT   <= transmit_slot_pointer;
            O_RX_RAW    <= I_RX_RAW && !sd_sync;
        end
    end

    // character shifter
    uart_char_tx #(
        .BAUD_DIV (BAUD_DIV)
    ) u_char (
        .i_clk     (I_CLK),
        .i_reset_n (I_RESET_N),
        .i_clr     (buf_clr),
        .i_start   (char_start),
        .i_char    (char_data),
        .i_odd     (I_TX_ODD_PARITY),
        .o_txd     (O_TXD),
        .o_busy    (char_busy),
        .o_done    (char_done)
    );

    // checks
    sequence s_clear;
        I_CLEAR_CMD;
    endsequence
    sequence s_ptrs_zero;
        load_slot_pointer == SLOT_FIRST && transmit_slot_pointer == SLOT_FIRST;
    endsequence

    property p_clear_ptrs;
        @(posedge I_CLK) disable iff (!I_RESET_N) s_clear |=> s_ptrs_zero;
    endproperty
    a_clear_ptrs: assert property (p_clear_ptrs)
        else $error("clear did not zero slot pointers");

    property p_full_hold;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        I_ADVANCE_CMD && ptr_full && !buf_clr
        |=> $stable(load_slot_pointer) && O_TX_OVERFLOW;
    endproperty
    a_full_hold: assert property (p_full_hold)
        else $error("advance while full changed pointer");

    property p_empty_flag;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        ##1 O_TX_EMPTY == $past(ptr_equal);
    endproperty
    a_empty_flag: assert property (p_empty_flag)
        else $error("empty status wrong");

    property p_no_load_send;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        st_reg == ST_DATA |-> transmit_slot_pointer != load_slot_pointer;
    endproperty
    a_no_load_send: assert property (p_no_load_send)
        else $error("load slot being transmitted");

    property p_len_clamp;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        I_BUF_WR && I_BUF_LOC == LOC_LEN && !I_TX_UNLIMITED
        && I_BUF_WDATA > LEN_LIMIT && !buf_clr
        |=> buf_mem[$past(load_slot_pointer)][0] == LEN_LIMIT;
    endproperty
    a_len_clamp: assert property (p_len_clamp)
        else $error("length not clamped");

    property p_pause;
        @(posedge I_CLK) disable iff (!I_RESET_N) I_TX_PAUSE |-> !char_start;
    endproperty
    a_pause: assert property (p_pause)
        else $error("character started while paused");

    property p_restore;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        st_reg == ST_DONE && !buf_clr
        |=> buf_mem[$past(transmit_slot_pointer)][0] == LEN_DEFAULT
            && transmit_slot_pointer == $past(transmit_slot_pointer) + 2'h1;
    endproperty
    a_restore: assert property (p_restore)
        else $error("slot not restored or pointer not stepped");

    property p_frame_chars;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        char_start && st_reg != ST_DATA && st_reg != ST_SINGLE
        |-> char_data == (st_reg == ST_PRE ? PREAMBLE_CHAR : STOP_CHAR);
    endproperty
    a_frame_chars: assert property (p_frame_chars)
        else $error("wrong framing character");

    property p_fill;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        char_start && st_reg == ST_DATA && I_TX_RAW && idx_reg > LAST_STORED
        |-> char_data == (idx_reg[0] ? FILL_ODD : FILL_EVEN);
    endproperty
    a_fill: assert property (p_fill)
        else $error("wrong fill byte");

endmodule

`default_nettype wire

/* File: hdl/uart_txq_pkg.sv */
// constants and types shared by the uart transmit queue block
package uart_txq_pkg;

    // clock and line rate
    localparam int CLK_PERIOD_NS = 4;
    localparam int CLK_HZ        = 250_000_000;
    localparam int BAUD_BPS_DEF  = 2_000_000;
    localparam int BAUD_DIV_DEF  = CLK_HZ / BAUD_BPS_DEF;

    // character framing
    localparam int         CHAR_BITS     = 12;
    localparam logic [7:0] PREAMBLE_CHAR = 8'h15;
    localparam logic [7:0] STOP_CHAR     = 8'h54;

    // transmit buffer geometry
    localparam int         NUM_SLOTS  = 4;
    localparam int         SLOT_BYTES = 7;
    localparam logic [2:0] LOC_LEN    = 3'h0;
    localparam logic [2:0] LOC_LAST   = 3'h6;
    localparam logic [1:0] SLOT_FIRST = 2'h0;

    // default contents and length limits
    localparam logic [7:0] LEN_DEFAULT   = 8'h00;
    localparam logic [7:0] FILL_ODD      = 8'hd3;
    localparam logic [7:0] FILL_EVEN     = 8'hc2;
    localparam logic [7:0] LEN_LIMIT     = 8'h3e;
    localparam logic [7:0] LEN_LIMIT_UNL = 8'hff;
    localparam logic [7:0] LAST_STORED   = 8'h06;

    // keep-alive interval coding
    localparam int         KA_MAX_NS     = 10_240_000;
    localparam int         KA_MAX_CYCLES = KA_MAX_NS / CLK_PERIOD_NS;
    localparam logic [3:0] KA_OFF        = 4'h0;
    localparam logic [3:0] KA_ZERO       = 4'h1;
    localparam logic [3:0] KA_TOP        = 4'hf;

    // transmit sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SINGLE,
        ST_PRE,
        ST_DATA,
        ST_STOP,
        ST_DONE
    } tx_state_t;

endpackage

/* File: verif/tb_top.sv */
// self-checking bench for the uart transmit queue
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import uart_txq_pkg::*;
    localparam logic [9:0] MT[4] = '{10'h081, 10'h031, 10'h0c1, 10'h085};
    localparam logic [7:0] LN[4] = '{8'h08, 8'h01, 8'h03, 8'h02};
    localparam logic [7:0] B1[4] = '{8'h57, 8'ha5, 8'h3c, 8'h81};
    logic       clk, rst_n, shut, wr, txd, busy, empty, full, ovf, got;
    logic       idle, rxraw;
    logic [1:0] cmd, lslot, tslot;
    logic [2:0] loc, rloc;
    logic [7:0] wd, space, rdata;
    logic [9:0] mode, ch;
    logic [3:0] ka;
    logic [9:0] rxq[$];
    logic [7:0] exq[$];
    int         errors, n_checks, cyc;
    uart_tx_queue #(.BAUD_DIV(4), .KA_MAX_CYCLES(64)) dut (
        .I_CLK(clk), .I_RESET_N(rst_n), .I_SHUTDOWN(shut), .I_BUF_WR(wr),
        .I_BUF_LOC(loc), .I_BUF_WDATA(wd), .I_BUF_RD_LOC(rloc),
        .I_CLEAR_CMD(cmd == 2'h1), .I_ADVANCE_CMD(cmd == 2'h2),
        .I_OVF_CLR(cmd == 2'h3),
        .O_BUF_RDATA(rdata), .I_TX_QUEUE(mode[0]), .I_TX_PREAMBLES(mode[1]),
        .I_KEEP_ALIVE(ka), .I_TX_UNLIMITED(mode[2]), .I_TX_PAUSE(mode[3]),
        .I_TX_ODD_PARITY(mode[4]), .I_TX_NO_STOP(mode[5]),
        .I_TX_NO_PREAMBLE(mode[6]), .I_TX_RAW(mode[7]), .I_RX_RAW(mode[8]),
        .I_RX_FULL(mode[9]), .I_RX_SPACE(space), .O_TXD(txd),
        .O_TX_BUSY(busy), .O_TX_IDLE(idle), .O_TX_EMPTY(empty),
        .O_TX_FULL(full),
        .O_TX_OVERFLOW(ovf), .O_LOAD_SLOT(lslot), .O_TX_SLOT(tslot),
        .O_RX_RAW(rxraw));
    uart_line_rx #(.DIV(4)) far (.i_clk(clk), .i_reset_n(rst_n),
        .i_txd(txd), .o_got(got), .o_char(ch));
    // clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // collect characters, cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (got === 1'b1) rxq.push_back(ch);
        if (cyc == 20000) begin
            errors++;
            end_sim;
        end
    end
    task automatic end_sim;
        if (errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic setm(input logic [9:0] m);
        @(posedge clk);
        mode <= m;
    endtask
    task automatic wr_b(input logic [2:0] l, input logic [7:0] d);
        @(posedge clk);
        {wr, loc, wd} <= {1'b1, l, d};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic pl(input logic [1:0] c);
        @(posedge clk);
        cmd <= c;
        @(posedge clk);
        cmd <= 2'h0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [2:0] l, input logic [7:0] e);
        @(posedge clk);
        rloc <= l;
        repeat (2) @(posedge clk);
        #1 chk(rdata, e);
    endtask
    function automatic logic [7:0] man(input logic [3:0] n);
        logic [7:0] r;
        for (int i = 0; i < 4; i++) r[2*i +: 2] = {~n[i], n[i]};
        return r;
    endfunction
    // wait for the message, then compare with the expected characters
    task automatic msg(input logic [7:0] len, input logic [7:0] b1);
        logic [7:0] v;
        exq.delete();
        if (!mode[6]) exq.push_back(PREAMBLE_CHAR);
        for (int i = 1; i <= len; i++) begin
            v = (i == 1) ? b1 : ((i % 2) ? FILL_ODD : FILL_EVEN);
            if (mode[7]) exq.push_back(v);
            else exq = {exq, man(v[3:0]), man(v[7:4])};
        end
        if (!mode[5]) exq.push_back(STOP_CHAR);
        for (int i = 0; i < 3000 && !(empty === 1'b1 && busy === 1'b0); i++)
            @(posedge clk);
        repeat (4) @(posedge clk);
        chk({7'h0, empty}, 8'h01);
        chk(8'(rxq.size()), 8'(exq.size()));
        foreach (exq[i]) begin
            chk(rxq[i][7:0], exq[i]);
            chk({6'h0, rxq[i][9], ^rxq[i][8:0]}, {7'h0, mode[4]});
        end
        rxq.delete();
    endtask
    initial begin
        {shut, wr, cmd, loc, rloc, wd, ka, errors, n_checks, cyc} = '0;
        mode = 10'h001;
        space = 8'hff;
        rst_n = 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1 chk({1'b0, empty, full, lslot, tslot, txd}, 8'h41);
        pl(2'h1);
        wr_b(3'h0, 8'hff);
        rd(3'h0, LEN_LIMIT);
        setm(10'h005);
        wr_b(3'h0, 8'hff);
        wr_b(3'h7, 8'h00);
        rd(3'h0, LEN_LIMIT_UNL);
        rd(3'h1, FILL_ODD);
        rd(3'h6, FILL_EVEN);
        for (int k = 0; k < 4; k++) begin
            setm(MT[k]);
            wr_b(3'h0, LN[k]);
            wr_b(3'h1, B1[k]);
            pl(2'h2);
            msg(LN[k], B1[k]);
            chk({6'h0, tslot}, 8'((k + 1) % 4));
        end
        rd(3'h0, LEN_DEFAULT);
        rd(3'h1, FILL_ODD);
        setm(10'h081);
        space <= 8'h02;
        wr_b(3'h0, 8'h03);
        pl(2'h2);
        repeat (100) @(posedge clk);
        #1 chk({7'h0, busy}, 8'h00);
        chk(8'(rxq.size()), 8'h00);
        setm(10'h085);
        msg(8'h03, FILL_ODD);
        setm(10'h000);
        pl(2'h2);
        pl(2'h2);
        pl(2'h2);
        chk({4'h0, full, ovf, lslot}, 8'h08);
        pl(2'h2);
        chk({4'h0, full, ovf, lslot}, 8'h0c);
        pl(2'h3);
        chk({4'h0, full, ovf, lslot}, 8'h08);
        pl(2'h1);
        chk({2'h0, empty, ovf, lslot, tslot}, 8'h20);
        for (int j = 0; j < 3; j++) begin
            setm(j ? 10'h001 : 10'h003);
            ka <= (j == 2) ? KA_TOP : (j ? KA_ZERO : KA_OFF);
            repeat (300) @(posedge clk);
            setm(10'h001);
            ka <= KA_OFF;
            repeat (100) @(posedge clk);
            chk(8'(rxq.size() > (j == 2 ? 1 : 3)), 8'h01);
            chk(8'(rxq.size() < (j == 2 ? 5 : 99)), 8'h01);
            foreach (rxq[i]) chk(rxq[i][7:0], j ? STOP_CHAR : PREAMBLE_CHAR);
            rxq.delete();
        end
        setm(10'h003);
        repeat (30) @(posedge clk);
        setm(10'h00b);
        repeat (200) @(posedge clk);
        #1 chk({6'h0, busy, idle}, 8'h02);
        chk(8'(rxq.size()), 8'h01);
        setm(10'h103);
        repeat (100) @(posedge clk);
        #1 chk({6'h0, rxq.size() > 1, rxraw}, 8'h03);
        @(posedge clk);
        shut <= 1'b1;
        repeat (6) @(posedge clk);
        #1 chk({5'h0, txd, busy, rxraw}, 8'h04);
        end_sim;
    end
endmodule
`default_nettype wire

/* File: verif/uart_line_rx.sv */
// far-side receiver model: decodes line characters
`timescale 1ns/1ps
`default_nettype none
module uart_line_rx #(
    parameter int DIV = 4
) (
    // clock, reset and line
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_txd,
    // {framing error, parity, data} of each character
    output logic            o_got,
    output logic      [9:0] o_char
);
    logic [10:0] sh_reg;
    logic        busy_reg;
    int          tick_reg;
    int          nbit_reg;
    // start detect, then mid-bit sampling lsb first
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            {sh_reg, busy_reg, o_got, o_char} <= '0;
            tick_reg <= 0;
            nbit_reg <= 0;
        end else begin
            o_got <= 1'b0;
            if (!busy_reg) begin
                busy_reg <= !i_txd;
                tick_reg <= 1;
                nbit_reg <= 0;
            end else begin
                tick_reg <= tick_reg + 1;
                if (tick_reg % DIV == DIV / 2) begin
                    sh_reg   <= {i_txd, sh_reg[10:1]};
                    nbit_reg <= nbit_reg + 1;
                    if (nbit_reg == 11) begin
                        busy_reg <= 1'b0;
                        o_got    <= 1'b1;
                        o_char   <= {sh_reg[0] | !sh_reg[10] | !i_txd,
                                     sh_reg[9:1]};
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire
